/* File: pfc_cfg.svh */
// Functional notes
// - The die temperature is an 8-bit read-only result, read as one byte, zero after reset.
// - The temperature result refreshes about once a second and reads return the latest value.
// - Temperature code N means -20 C plus N times 0.652 C, full scale 146.2 C.
// - With the current-limit gang bit set, a current-limit fault on either channel turns both off, else only the faulted one.
// - With the power-cut gang bit set, a two-pair power-cut fault on either channel turns both off, else only the faulted one.
// - In automatic mode both gang bits of a port are set at turn-on of a four-pair single-signature load.
// - The summed-power-cut enable bit switches summed four-pair policing of its port on or off.
// - Current-limit faults are acted on whatever the summed-power-cut enable bits hold.
// - In automatic and semi-automatic mode the summed-power-cut enable bit is set at turn-on of a single-signature load.
// - The disconnect threshold bit selects 4.5 mA when one and 6.5 mA when zero.
// - Dual-signature loads get the threshold bit set at turn-on and each channel is disconnected on its own.
// - Single-signature loads get the threshold bit from the class at turn-on: zero for 1-4, one for 5-8.
// - The fault setup register sits at command 2Dh, one byte, read and write, zero after reset.
// - The temperature register sits at command 2Ch, one byte, read only.
// - Summed power-cut checking pauses during partial disconnect or while a channel is below about 30 mA.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

`define PFC_CMD_TEMP 8'h2c
`define PFC_CMD_FAULT 8'h2d
`define PFC_FAULT_RESET 8'h00
`define PFC_TEMP_RESET 8'h00
`define PFC_CURRENT_LIMIT_LSB 6
`define PFC_CUT_LSB 4
`define PFC_PPCT_LSB 2
`define PFC_DCDT_LSB 0
`define PFC_CLASS_HIGH_MIN 4'h5
`define PFC_CLK_HZ 50000000
`define PFC_TEMP_PERIOD_MS 1000
`define PFC_TEMP_TICK_CYCLES ((`PFC_CLK_HZ / 1000) * `PFC_TEMP_PERIOD_MS)
`define PFC_TEMP_OFFSET_C -20
`define PFC_TEMP_STEP_MILLI_C 652
`define PFC_TEMP_FULL_DECI_C 1462

`endif

/* File: pfc_pkg.sv */
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_MODE_OFF = 2'b00,
    PFC_MODE_MANUAL = 2'b01,
    PFC_MODE_SEMI = 2'b10,
    PFC_MODE_AUTO = 2'b11
  } pfc_mode_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [3:0] ch_off;
    logic [1:0] cut_trip;
  } pfc_top_st_t;
endpackage

/* File: pfc_temp_conv.sv */
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_temp_conv #(
  parameter int TICK_CYCLES = `PFC_TEMP_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Converter result
  input wire logic [7:0] adc_code,
  // Held reading
  output logic [7:0] die_temperature_code,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [7:0] temp;
  } pfc_temp_st_t;

  pfc_temp_st_t s_q;
  pfc_temp_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
      // Code is passed unscaled, -20 C plus code times the step
      s_d.temp = adc_code;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{cnt: '0, temp: `PFC_TEMP_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign die_temperature_code = s_q.temp;
  assign tick = (s_q.cnt == LAST);

  property p_temp_hold;
    @(posedge clk) disable iff (!rst_n)
      !tick |=> $stable(die_temperature_code);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temperature changed between updates");

  property p_temp_load;
    @(posedge clk) disable iff (!rst_n)
      tick |=> die_temperature_code == $past(adc_code);
  endproperty
  a_temp_load: assert property (p_temp_load) else $error("temperature not loaded on tick");
endmodule

/* File: pfc_top.sv */
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_top #(
  parameter int TEMP_TICK_CYCLES = `PFC_TEMP_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // Port turn-on context
  input wire logic [1:0] turn_on,
  input pfc_pkg::pfc_mode_t [1:0] port_mode,
  input wire logic [1:0] port_dual_sig,
  input wire logic [1:0][3:0] port_class,
  // Channel monitors
  input wire logic [3:0] current_limit_fault,
  input wire logic [3:0] pcut2_fault,
  input wire logic [3:0] below_disc,
  input wire logic [3:0] below_30ma,
  input wire logic [1:0] partial_disc,
  input wire logic [1:0] summed_over,
  input wire logic [7:0] adc_temp_code,
  // Control outputs
  output logic [3:0] ch_off,
  output logic [1:0] summed_cut_trip,
  output logic [1:0] summed_check_active,
  output logic [1:0] dc_thresh_low
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] temp_code;
  pfc_pkg::pfc_top_st_t s_q;
  pfc_pkg::pfc_top_st_t s_d;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  pfc_temp_conv #(
    .TICK_CYCLES(TEMP_TICK_CYCLES)
  ) u_temp (
    .clk(clk),
    .rst_n(rst_n),
    .adc_code(adc_temp_code),
    .die_temperature_code(temp_code),
    .tick()
  );

  function automatic logic [7:0] read_mux(input logic [7:0] code, input logic [7:0] temp,
                                          input logic [7:0] cfg);
    case (code)
      `PFC_CMD_TEMP: read_mux = temp;
      `PFC_CMD_FAULT: read_mux = cfg;
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    logic [1:0] pair;
    logic single;
    logic active;
    pair = 2'h0;
    single = 1'b0;
    active = 1'b0;
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.ch_off = 4'h0;
    s_d.cut_trip = 2'h0;
    summed_check_active = 2'h0;
    if (cmd_valid && cmd_write && cmd_code == `PFC_CMD_FAULT) begin
      s_d.cfg = cmd_wdata;
    end
    if (cmd_valid && !cmd_write) begin
      s_d.rsp_valid = 1'b1;
      s_d.rsp_data = read_mux(cmd_code, temp_code, s_q.cfg);
    end
    for (int p = 0; p < 2; p++) begin
      single = !port_dual_sig[p];
      // Turn-on updates come after the host write so hardware wins
      if (turn_on[p]) begin
        if (single && port_mode[p] == pfc_pkg::PFC_MODE_AUTO) begin
          s_d.cfg[`PFC_CURRENT_LIMIT_LSB + p] = 1'b1;
          s_d.cfg[`PFC_CUT_LSB + p] = 1'b1;
        end
        if (single && (port_mode[p] == pfc_pkg::PFC_MODE_AUTO ||
                       port_mode[p] == pfc_pkg::PFC_MODE_SEMI)) begin
          s_d.cfg[`PFC_PPCT_LSB + p] = 1'b1;
        end
        if (!single) begin
          s_d.cfg[`PFC_DCDT_LSB + p] = 1'b1;
        end else begin
          s_d.cfg[`PFC_DCDT_LSB + p] = (port_class[p] >= `PFC_CLASS_HIGH_MIN);
        end
      end
      pair = current_limit_fault[2*p +: 2];
      if (s_q.cfg[`PFC_CURRENT_LIMIT_LSB + p]) begin
        s_d.ch_off[2*p +: 2] = s_d.ch_off[2*p +: 2] | {2{|pair}};
      end else begin
        s_d.ch_off[2*p +: 2] = s_d.ch_off[2*p +: 2] | pair;
      end
      pair = pcut2_fault[2*p +: 2];
      if (s_q.cfg[`PFC_CUT_LSB + p]) begin
        s_d.ch_off[2*p +: 2] = s_d.ch_off[2*p +: 2] | {2{|pair}};
      end else begin
        s_d.ch_off[2*p +: 2] = s_d.ch_off[2*p +: 2] | pair;
      end
      active = s_q.cfg[`PFC_PPCT_LSB + p] && !partial_disc[p] &&
               !(|below_30ma[2*p +: 2]);
      summed_check_active[p] = active;
      if (active && summed_over[p]) begin
        s_d.cut_trip[p] = 1'b1;
        s_d.ch_off[2*p +: 2] = 2'h3;
      end
      pair = below_disc[2*p +: 2];
      if (!single || !s_q.cfg[`PFC_DCDT_LSB + p]) begin
        s_d.ch_off[2*p +: 2] = s_d.ch_off[2*p +: 2] | pair;
      end else if (&pair) begin
        s_d.ch_off[2*p +: 2] = 2'h3;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{cfg: `PFC_FAULT_RESET, rsp_valid: 1'b0, rsp_data: 8'h00,
               ch_off: 4'h0, cut_trip: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid = s_q.rsp_valid;
  assign rsp_data = s_q.rsp_data;
  assign ch_off = s_q.ch_off;
  assign summed_cut_trip = s_q.cut_trip;
  assign dc_thresh_low = {s_q.cfg[`PFC_DCDT_LSB + 1], s_q.cfg[`PFC_DCDT_LSB]};

  sequence s_read_temp;
    cmd_valid && !cmd_write && cmd_code == `PFC_CMD_TEMP;
  endsequence

  sequence s_write_cfg;
    cmd_valid && cmd_write && cmd_code == `PFC_CMD_FAULT && turn_on == 2'h0;
  endsequence

  property p_temp_read;
    @(posedge clk) disable iff (!rst_n)
      s_read_temp |=> rsp_valid && rsp_data == $past(temp_code);
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("temperature read wrong");

  property p_cfg_rw;
    @(posedge clk) disable iff (!rst_n)
      s_write_cfg ##1 (cmd_valid && !cmd_write && cmd_code == `PFC_CMD_FAULT && !cmd_write)
      |=> rsp_data == $past(cmd_wdata, 2);
  endproperty
  a_cfg_rw: assert property (p_cfg_rw) else $error("setup register readback wrong");

  property p_temp_ro;
    @(posedge clk) disable iff (!rst_n)
      cmd_valid && cmd_write && cmd_code == `PFC_CMD_TEMP && turn_on == 2'h0
      |=> s_q.cfg == $past(s_q.cfg);
  endproperty
  a_temp_ro: assert property (p_temp_ro) else $error("temperature write had effect");

  property p_current_limit_gang;
    @(posedge clk) disable iff (!rst_n)
      s_q.cfg[`PFC_CURRENT_LIMIT_LSB] && current_limit_fault[0] |=> ch_off[1:0] == 2'h3;
  endproperty
  a_current_limit_gang: assert property (p_current_limit_gang) else $error("ganged limit fault kept a channel on");

  property p_cut_gang;
    @(posedge clk) disable iff (!rst_n)
      s_q.cfg[`PFC_CUT_LSB + 1] && pcut2_fault[3] |=> ch_off[3:2] == 2'h3;
  endproperty
  a_cut_gang: assert property (p_cut_gang) else $error("ganged cut fault kept a channel on");

  property p_current_limit_always;
    @(posedge clk) disable iff (!rst_n)
      current_limit_fault[2] |=> ch_off[2];
  endproperty
  a_current_limit_always: assert property (p_current_limit_always) else $error("limit fault ignored");

  property p_auto_gang;
    @(posedge clk) disable iff (!rst_n)
      turn_on[1] && !port_dual_sig[1] && port_mode[1] == pfc_pkg::PFC_MODE_AUTO
      |=> s_q.cfg[7] && s_q.cfg[5] && s_q.cfg[3];
  endproperty
  a_auto_gang: assert property (p_auto_gang) else $error("auto turn-on bits not set");

  property p_semi_ppct;
    @(posedge clk) disable iff (!rst_n)
      turn_on[0] && !port_dual_sig[0] && port_mode[0] == pfc_pkg::PFC_MODE_SEMI
      |=> s_q.cfg[2];
  endproperty
  a_semi_ppct: assert property (p_semi_ppct) else $error("semi turn-on enable not set");

  property p_summed_trip;
    @(posedge clk) disable iff (!rst_n)
      summed_over[0] && !s_q.cfg[`PFC_PPCT_LSB] |=> !summed_cut_trip[0];
  endproperty
  a_summed_trip: assert property (p_summed_trip) else $error("summed cut while disabled");

  property p_suspend;
    @(posedge clk) disable iff (!rst_n)
      (partial_disc[1] || below_30ma[3]) |=> !summed_cut_trip[1];
  endproperty
  a_suspend: assert property (p_suspend) else $error("summed cut during suspend");

  property p_class_dcdt;
    @(posedge clk) disable iff (!rst_n)
      turn_on[0] && !port_dual_sig[0]
      |=> dc_thresh_low[0] == ($past(port_class[0]) >= `PFC_CLASS_HIGH_MIN);
  endproperty
  a_class_dcdt: assert property (p_class_dcdt) else $error("class threshold wrong");

  property p_dual_dcdt;
    @(posedge clk) disable iff (!rst_n)
      turn_on[1] && port_dual_sig[1] |=> dc_thresh_low[1];
  endproperty
  a_dual_dcdt: assert property (p_dual_dcdt) else $error("dual threshold not set");

  property p_dual_indep;
    @(posedge clk) disable iff (!rst_n)
      port_dual_sig[0] && below_disc[0] && !below_disc[1] && current_limit_fault[1:0] == 2'h0 &&
      pcut2_fault[1:0] == 2'h0 && !summed_over[0] |=> ch_off[1:0] == 2'h1;
  endproperty
  a_dual_indep: assert property (p_dual_indep) else $error("dual disconnect not per channel");
endmodule

/* File: pfc_host_model.sv */
`timescale 1ns/1ps
module pfc_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid = 1'b0,
  output logic cmd_write = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [7:0] cmd_wdata = 8'h00,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data
);
  // One byte per command, held until the taking edge
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~data;
  endtask
  // Write then read back on the very next cycle, as the port allows
  task automatic wr_rd(input logic [7:0] code, input logic [7:0] data, output logic [7:0] rdata);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_write <= 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    rdata = (rsp_valid === 1'b1) ? rsp_data : 8'hxx;
  endtask
  // Read waits a bounded time for the answer byte
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    data = 8'hxx;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    cmd_code <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (rsp_valid === 1'b1) begin
        data = rsp_data;
        break;
      end
      @(posedge clk);
    end
  endtask
endmodule

/* File: pfc_top_tb_top.sv */
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_top_tb_top;
  localparam int TICK = 16;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_write, rsp_valid;
  logic [7:0] cmd_code, cmd_wdata, rsp_data, d, v;
  logic [1:0] turn_on = 2'b00;
  pfc_pkg::pfc_mode_t [1:0] port_mode;
  logic [1:0] port_dual_sig = 2'b00;
  logic [1:0][3:0] port_class = '0;
  logic [3:0] current_limit_fault = 4'h0, pcut2_fault = 4'h0, below_30ma = 4'h0, off;
  logic [3:0] below_disc = 4'h0;
  logic [1:0] partial_disc = 2'b00, summed_over = 2'b00, trip;
  logic [7:0] adc_temp_code = 8'h00;
  logic [3:0] ch_off;
  logic [1:0] summed_cut_trip, summed_check_active, dc_thresh_low;
  logic [15:0] lf = 16'he6d7;
  int err_count = 0;
  int cmp_count = 0;
  pfc_pkg::pfc_mode_t modes [3] = '{pfc_pkg::PFC_MODE_SEMI, pfc_pkg::PFC_MODE_AUTO,
                                    pfc_pkg::PFC_MODE_MANUAL};
  always #10 clk = ~clk;
  pfc_top #(.TEMP_TICK_CYCLES(TICK)) pfc_top_inst (.clk(clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .turn_on(turn_on), .port_mode(port_mode),
    .port_dual_sig(port_dual_sig), .port_class(port_class), .current_limit_fault(current_limit_fault),
    .pcut2_fault(pcut2_fault), .below_disc(below_disc), .below_30ma(below_30ma),
    .partial_disc(partial_disc), .summed_over(summed_over), .adc_temp_code(adc_temp_code),
    .ch_off(ch_off), .summed_cut_trip(summed_cut_trip),
    .summed_check_active(summed_check_active), .dc_thresh_low(dc_thresh_low));
  pfc_host_model pfc_host_model_inst (.clk(clk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  function automatic logic [7:0] rnd8();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  // Off request per channel: a gang bit widens a fault to the whole port
  function automatic logic [3:0] exp_off(input logic [3:0] f, input logic [1:0] gang);
    exp_off = f;
    for (int p = 0; p < 2; p++) begin
      if (gang[p] && f[2*p +: 2] != 2'b00) begin
        exp_off[2*p +: 2] = 2'b11;
      end
    end
  endfunction
  // Disconnect request: per channel unless a single-signature port uses the low threshold
  function automatic logic [1:0] exp_disc(input logic dual, input logic th, input logic [1:0] b);
    exp_disc = (dual || !th) ? b : {2{&b}};
  endfunction
  // Setup byte after a turn-on from a cleared register
  function automatic logic [7:0] exp_on(input int p, input pfc_pkg::pfc_mode_t m,
                                        input logic dual, input logic [3:0] cls);
    exp_on = 8'h00;
    if (dual) begin
      exp_on[p] = 1'b1;
    end else begin
      exp_on[6 + p] = (m == pfc_pkg::PFC_MODE_AUTO);
      exp_on[4 + p] = (m == pfc_pkg::PFC_MODE_AUTO);
      exp_on[2 + p] = (m == pfc_pkg::PFC_MODE_AUTO) || (m == pfc_pkg::PFC_MODE_SEMI);
      exp_on[p] = (cls >= 4'h5);
    end
  endfunction
  task automatic fault(input logic [3:0] il, input logic [3:0] pc, input logic [1:0] so);
    @(posedge clk);
    current_limit_fault <= il;
    pcut2_fault <= pc;
    summed_over <= so;
    @(posedge clk);
    current_limit_fault <= 4'h0;
    pcut2_fault <= 4'h0;
    summed_over <= 2'b00;
    #1;
    off = ch_off;
    trip = summed_cut_trip;
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    port_mode[0] = pfc_pkg::PFC_MODE_MANUAL;
    port_mode[1] = pfc_pkg::PFC_MODE_MANUAL;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    pfc_host_model_inst.rd(`PFC_CMD_FAULT, d);
    check("setup reset", `PFC_FAULT_RESET, d);
    pfc_host_model_inst.rd(`PFC_CMD_TEMP, d);
    check("temp reset", `PFC_TEMP_RESET, d);
    for (int i = 0; i < 8; i++) begin
      v = rnd8();
      pfc_host_model_inst.wr_rd(`PFC_CMD_FAULT, v, d);
      check("setup rw", v, d);
      check("thresh", {6'h00, v[1:0]}, {6'h00, dc_thresh_low});
    end
    pfc_host_model_inst.wr(`PFC_CMD_TEMP, 8'h5a);
    pfc_host_model_inst.rd(`PFC_CMD_TEMP, d);
    check("temp read only", 8'h00, d);
    pfc_host_model_inst.rd(8'h2e, d);
    check("unknown code", 8'h00, d);
    for (int i = 0; i < 4; i++) begin
      v = rnd8();
      @(posedge clk);
      adc_temp_code <= (i == 0) ? 8'hff : v;
      repeat (2 * TICK) @(posedge clk);
      pfc_host_model_inst.rd(`PFC_CMD_TEMP, d);
      check("temp", (i == 0) ? 8'hff : v, d);
    end
    for (int g = 0; g < 4; g++) begin
      pfc_host_model_inst.wr(`PFC_CMD_FAULT, {g[1:0], g[1:0], g[1:0], 2'b00});
      for (int c = 0; c < 4; c++) begin
        fault(4'h1 << c, 4'h0, 2'b00);
        check("current_limit off", {4'h0, exp_off(4'h1 << c, g[1:0])}, {4'h0, off});
        fault(4'h0, 4'h1 << c, 2'b00);
        check("cut off", {4'h0, exp_off(4'h1 << c, g[1:0])}, {4'h0, off});
      end
    end
    for (int q = 0; q < 2; q++) begin
      pfc_host_model_inst.wr(`PFC_CMD_FAULT, 8'h04 << q);
      for (int k = 0; k < 3; k++) begin
        @(posedge clk);
        partial_disc <= 2'(k == 1) << q;
        below_30ma <= 4'(k == 2) << (2 * q + 1);
        @(posedge clk);
        #1;
        check("sum active", 8'(k == 0) << q, {6'h00, summed_check_active});
        fault(4'h0, 4'h0, 2'b11);
        check("sum trip", 8'(k == 0) << q, {6'h00, trip});
        check("sum off", (k == 0) ? 8'h03 << (2 * q) : 8'h00, {4'h0, off});
      end
    end
    @(posedge clk);
    partial_disc <= 2'b00;
    below_30ma <= 4'h0;
    for (int t = 0; t < 32; t++) begin
      pfc_host_model_inst.wr(`PFC_CMD_FAULT, {7'h00, t[2]} << t[4]);
      @(posedge clk);
      port_dual_sig[t[4]] <= t[3];
      below_disc <= {2'b00, t[1:0]} << (2 * t[4]);
      @(posedge clk);
      below_disc <= 4'h0;
      #1;
      v = {6'h00, exp_disc(t[3], t[2], t[1:0])} << (2 * t[4]);
      check("disc off", v, {4'h0, ch_off});
    end
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 6; k++) begin
        v = rnd8();
        pfc_host_model_inst.wr(`PFC_CMD_FAULT, 8'h00);
        @(posedge clk);
        port_mode[v[3]] <= modes[m];
        port_dual_sig[v[3]] <= k[0];
        port_class[v[3]] <= (k < 2) ? 4'h4 : (k < 4) ? 4'h5 : {1'b0, v[2:0]} + 4'h1;
        turn_on[v[3]] <= 1'b1;
        @(posedge clk);
        turn_on <= 2'b00;
        pfc_host_model_inst.rd(`PFC_CMD_FAULT, d);
        check("turn on", exp_on(v[3], modes[m], k[0], port_class[v[3]]), d);
      end
    end
    tally_and_finish();
  end
endmodule
